// *** src/hsst_top.sv ***
// Hot swap start-up limit selection and timer-pin sequencer.
// Assumes comparator levels arrive asynchronously and references as codes.
`timescale 1ns/100ps
`default_nettype none
module hsst_top
  import hsst_pkg::*;
#(
  parameter int INIT_MIN_CYC = hsst_pkg::HSST_INIT_MIN_CYC,
  parameter longint RETRY_CYC = hsst_pkg::HSST_RETRY_CYC,
  parameter int RST_CYC = hsst_pkg::HSST_RST_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic operation_on,
  input wire logic [7:0] main_limit_pin,
  input wire logic [7:0] foldback_power_pin,
  input wire logic [7:0] startup_limit_pin,
  input wire logic [7:0] sense_level,
  input wire logic timer_low_cmp,
  input wire logic timer_high_cmp,
  input wire logic undervoltage_input,
  input wire logic overvoltage_input,
  input wire logic power_good_cmp,
  input wire logic retry_select,
  output logic gate_on,
  output logic gate_regulate,
  output logic [7:0] limit_ref,
  output logic [7:0] breaker_trip_level,
  output logic timer_up3,
  output logic timer_up60,
  output logic timer_dn2,
  output logic timer_dn100,
  output logic timer_clamp_low,
  output logic fault_n,
  output logic power_good,
  output logic [3:0] seq_state
);
  import hsst_pkg::*;

  // Synchronised comparator results.
  logic [5:0] cmp_sync;
  logic tmr_low; // Timer below 0.2 V.
  logic tmr_high; // Timer at or above 1 V.
  logic uv_ok;
  logic ov_bad;
  logic pg_cmp;
  logic retry_low;
  hsst_state_type state_r, state_nxt;
  hsst_src_type src_nxt;
  logic [3:0] frac_r;
  logic [31:0] cnt_r;
  logic [35:0] retry_r;
  logic uv_prev_r;
  logic op_prev_r;
  logic reenable;
  logic in_window;
  logic [7:0] sel_ref;
  logic [7:0] start_ref;
  logic [7:0] ref_nxt;
  logic [7:0] trip_nxt;
  logic pg_r;

  // Comparator synchroniser bank.
  hsst_sync #(
    .WIDTH(6)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({timer_low_cmp, timer_high_cmp, undervoltage_input,
      overvoltage_input, power_good_cmp, retry_select}),
    .sync_out(cmp_sync)
  );

  assign tmr_low = cmp_sync[5];
  assign tmr_high = cmp_sync[4];
  assign uv_ok = cmp_sync[3];
  assign ov_bad = cmp_sync[2];
  assign pg_cmp = cmp_sync[1];
  assign retry_low = ~cmp_sync[0];
  assign in_window = uv_ok & ~ov_bad;

  // Lower of two codes.
  function automatic logic [7:0] min8(input logic [7:0] a,
                                      input logic [7:0] b);
    min8 = (a < b) ? a : b;
  endfunction

  // Raise a code to a floor.
  function automatic logic [7:0] floor8(input logic [7:0] a,
                                        input logic [7:0] f);
    floor8 = (a < f) ? f : a;
  endfunction

  // Fraction register; defaults to maximum so it does not limit.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      frac_r <= HSST_FRAC_RESET;
    else if (reg_wr && reg_addr == HSST_FRAC_ADDR)
      frac_r <= reg_wdata[3:0];
  end

  // Readback; unmapped addresses read zero.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_addr == HSST_FRAC_ADDR)
      reg_rdata <= {4'h0, frac_r};
    else
      reg_rdata <= 8'h00;
  end

  // Reference selection, combinational.
  always_comb
  begin
    logic [12:0] prod;
    logic [7:0] reg_ref;
    prod = 13'(main_limit_pin) * 13'({1'b0, frac_r} + 5'h01);
    reg_ref = prod[11:4];
    start_ref = floor8(min8(startup_limit_pin, reg_ref),
      HSST_START_FLOOR);
    sel_ref = min8(main_limit_pin, foldback_power_pin);
    if (!pg_r)
      sel_ref = min8(sel_ref, start_ref);
    ref_nxt = floor8(sel_ref, HSST_REF_FLOOR);
    // Offset trips the breaker just before the limit; never wraps below 0.
    trip_nxt = (ref_nxt > HSST_CB_OFFSET) ? ref_nxt - HSST_CB_OFFSET
      : 8'h00;
  end

  // Registered references, so outputs come from flip-flops.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      limit_ref <= HSST_REF_FLOOR;
      breaker_trip_level <= 8'h00;
    end
    else
    begin
      limit_ref <= ref_nxt;
      breaker_trip_level <= trip_nxt;
    end
  end

  // Edge memory for the re-enable toggles.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      uv_prev_r <= 1'b0;
      op_prev_r <= 1'b1; // Idle on, so leaving reset is not an edge.
    end
    else
    begin
      uv_prev_r <= uv_ok;
      op_prev_r <= operation_on;
    end
  end
  assign reenable = (uv_ok & ~uv_prev_r) | (operation_on & ~op_prev_r);

  // Next-state logic; the timer source is decoded from its result below.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      HSST_ST_RESET:
      begin
        if (cnt_r >= 32'(RST_CYC))
          state_nxt = HSST_ST_INIT_UP;
      end
      HSST_ST_INIT_UP:
      begin
        if (tmr_high && cnt_r >= 32'(INIT_MIN_CYC))
          state_nxt = HSST_ST_INIT_DN;
      end
      HSST_ST_INIT_DN:
      begin
        if (tmr_low)
          state_nxt = HSST_ST_WAIT;
      end
      HSST_ST_WAIT:
      begin
        if (in_window && operation_on)
          state_nxt = HSST_ST_ON;
      end
      HSST_ST_ON:
      begin
        if (!in_window || !operation_on)
          state_nxt = HSST_ST_WAIT;
        else if (sense_level >= breaker_trip_level)
          state_nxt = HSST_ST_BREAKER;
      end
      HSST_ST_BREAKER:
      begin
        if (tmr_high)
          state_nxt = retry_low ? HSST_ST_RETRY
            : HSST_ST_LATCH_DN;
        else if (sense_level < breaker_trip_level)
          state_nxt = HSST_ST_COOL;
      end
      HSST_ST_COOL:
      begin
        if (!in_window || !operation_on)
          state_nxt = HSST_ST_WAIT;
        else if (sense_level >= breaker_trip_level)
          state_nxt = HSST_ST_BREAKER;
        else if (tmr_low)
          state_nxt = HSST_ST_ON;
      end
      HSST_ST_LATCH_DN:
      begin
        if (tmr_low)
          state_nxt = HSST_ST_LATCHED;
      end
      HSST_ST_LATCHED:
      begin
        if (reenable)
          state_nxt = HSST_ST_WAIT;
      end
      HSST_ST_RETRY:
      begin
        if (tmr_low && retry_r >= 36'(RETRY_CYC))
          state_nxt = HSST_ST_WAIT;
      end
      default:
        state_nxt = HSST_ST_RESET;
    endcase
  end

  // State register.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      state_r <= HSST_ST_RESET;
    else
      state_r <= state_nxt;
  end

  // Timer source of the state being entered, so the source switches on the
  // same edge as seq_state; one source per state keeps them exclusive.
  always_comb
  begin
    case (state_nxt)
      HSST_ST_INIT_UP:
        src_nxt = HSST_SRC_UP3;
      HSST_ST_INIT_DN:
        src_nxt = HSST_SRC_DN100;
      HSST_ST_BREAKER:
        src_nxt = HSST_SRC_UP60;
      HSST_ST_COOL:
        src_nxt = HSST_SRC_DN2;
      HSST_ST_LATCH_DN:
        src_nxt = HSST_SRC_DN2;
      HSST_ST_RETRY:
        src_nxt = HSST_SRC_DN2;
      default:
        src_nxt = HSST_SRC_NONE;
    endcase
  end

  // Phase counter, restarts on every state change.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || state_nxt != state_r)
      cnt_r <= 32'h0000_0000;
    else if (cnt_r != 32'hffff_ffff)
      cnt_r <= cnt_r + 32'h0000_0001;
  end

  // Retry delay counter, 36 bits wide; 10 s at 50 MHz is 500000000 cycles.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || state_r != HSST_ST_RETRY)
      retry_r <= 36'h0_0000_0000;
    else if (retry_r < 36'(RETRY_CYC))
      retry_r <= retry_r + 36'h0_0000_0001;
  end

  // Power good follows its comparator only while the gate is on.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      pg_r <= 1'b0;
    else
      pg_r <= pg_cmp && (state_nxt == HSST_ST_ON || state_nxt == HSST_ST_COOL
        || state_nxt == HSST_ST_BREAKER);
  end
  assign power_good = pg_r;

  // Timer source and gate outputs, registered from the next state.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      timer_up3 <= 1'b0;
      timer_up60 <= 1'b0;
      timer_dn2 <= 1'b0;
      timer_dn100 <= 1'b0;
      timer_clamp_low <= 1'b1;
      gate_on <= 1'b0;
      gate_regulate <= 1'b0;
      seq_state <= 4'h0;
    end
    else
    begin
      timer_up3 <= src_nxt == HSST_SRC_UP3;
      timer_up60 <= src_nxt == HSST_SRC_UP60;
      timer_dn2 <= src_nxt == HSST_SRC_DN2;
      timer_dn100 <= src_nxt == HSST_SRC_DN100;
      timer_clamp_low <= state_nxt == HSST_ST_RESET;
      gate_on <= state_nxt == HSST_ST_ON || state_nxt == HSST_ST_COOL
        || state_nxt == HSST_ST_BREAKER;
      gate_regulate <= state_nxt == HSST_ST_BREAKER;
      seq_state <= state_nxt;
    end
  end

  // Fault is latched low on an overcurrent shutdown; cleared on re-enable, or in retry mode when the retry delay ends.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      fault_n <= 1'b1;
    else if (state_r == HSST_ST_BREAKER && state_nxt != HSST_ST_BREAKER
             && state_nxt != HSST_ST_COOL)
      fault_n <= 1'b0;
    else if (state_r != HSST_ST_WAIT && state_nxt == HSST_ST_WAIT
             && state_r != HSST_ST_ON && state_r != HSST_ST_COOL)
      fault_n <= 1'b1;
  end
endmodule // hsst_top
`default_nettype wire

// *** src/hsst_pkg.sv ***
// Package for the hot swap start-up timer sequencer.
// Assumes a 50 MHz system clock; analog levels are 8-bit reference codes.
package hsst_pkg;
  // Register map.
  localparam logic [7:0] HSST_FRAC_ADDR = 8'hf6;
  localparam logic [3:0] HSST_FRAC_RESET = 4'hf;
  localparam int HSST_FRAC_DEN = 16;
  // Reference codes: 8 bits, 10 mV per LSB of comparator reference.
  localparam logic [7:0] HSST_REF_FLOOR = 8'h0a;
  // 2 mV sense floor times gain 50 gives the same 100 mV floor.
  localparam logic [7:0] HSST_START_FLOOR = 8'h0a;
  // Breaker offset 0.88 mV sense times 50 is 44 mV, about 4 codes.
  localparam logic [7:0] HSST_CB_OFFSET = 8'h04;
  // Timing.
  localparam int HSST_CLK_HZ = 50_000_000;
  localparam int HSST_INIT_MIN_MS = 27;
  localparam int HSST_INIT_MIN_CYC = HSST_INIT_MIN_MS * (HSST_CLK_HZ / 1000);
  localparam int HSST_RETRY_S = 10;
  localparam longint HSST_RETRY_CYC = longint'(HSST_RETRY_S) * HSST_CLK_HZ;
  localparam int HSST_RST_CYC = 4;
  // Sequencer states.
  typedef enum logic [3:0] {
    HSST_ST_RESET = 4'h0,
    HSST_ST_INIT_UP = 4'h1,
    HSST_ST_INIT_DN = 4'h2,
    HSST_ST_WAIT = 4'h3,
    HSST_ST_ON = 4'h4,
    HSST_ST_BREAKER = 4'h5,
    HSST_ST_COOL = 4'h6,
    HSST_ST_LATCH_DN = 4'h7,
    HSST_ST_LATCHED = 4'h8,
    HSST_ST_RETRY = 4'h9
  } hsst_state_type;
  // Timer current source select, one-hot so only one source is on.
  typedef enum logic [3:0] {
    HSST_SRC_NONE = 4'h0,
    HSST_SRC_UP3 = 4'h1,
    HSST_SRC_UP60 = 4'h2,
    HSST_SRC_DN2 = 4'h4,
    HSST_SRC_DN100 = 4'h8
  } hsst_src_type;
endpackage

// *** src/hsst_sync.sv ***
// Two-flop synchroniser bank for comparator results.
// Assumes the comparators are asynchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
module hsst_sync #(
  parameter int WIDTH = 6
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  // The first stage feeds only the second stage.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // hsst_sync
`default_nettype wire

// *** verif/hsst_top_asserts.sv ***
// Checker for hsst_top, attached by bind from the testbench.
// Assumes it sees only the top module's ports.
`timescale 1ns/100ps
`default_nettype none
module hsst_top_asserts
  import hsst_pkg::*;
#(
  parameter int INIT_MIN_CYC = 20
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] limit_ref,
  input wire logic [7:0] breaker_trip_level,
  input wire logic gate_on,
  input wire logic gate_regulate,
  input wire logic timer_up3,
  input wire logic timer_up60,
  input wire logic timer_dn2,
  input wire logic timer_dn100,
  input wire logic timer_clamp_low,
  input wire logic fault_n,
  input wire logic power_good,
  input wire logic [3:0] seq_state
);
  int up_cnt_r;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Length of the running pull-up phase; too short a phase fails AST_UP3_MIN.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !timer_up3)
      up_cnt_r <= 0;
    else
      up_cnt_r <= up_cnt_r + 1;
  end
  AST_RST_HOLD: assert property (disable iff (1'b0)
    !rst_n |=> !gate_on && timer_clamp_low && fault_n && !power_good)
    else $error("outputs not held during reset");
  AST_ONE_SRC: assert property (
    $onehot0({timer_up3, timer_up60, timer_dn2, timer_dn100}))
    else $error("two timer sources on");
  AST_UP3_MIN: assert property (
    $fell(timer_up3) |-> up_cnt_r >= INIT_MIN_CYC)
    else $error("pull-up phase too short");
  AST_INIT_UP: assert property (
    seq_state == HSST_ST_INIT_UP |-> timer_up3 && !gate_on)
    else $error("initial pull-up missing");
  AST_INIT_DN: assert property (
    seq_state == HSST_ST_INIT_DN |-> timer_dn100 && !gate_on)
    else $error("initial discharge missing");
  AST_BREAKER: assert property (
    seq_state == HSST_ST_BREAKER |-> timer_up60 && gate_regulate)
    else $error("breaker phase wrong");
  AST_LATCH_DN: assert property (
    seq_state == HSST_ST_LATCH_DN |-> timer_dn2 && !gate_on)
    else $error("restart during latch discharge");
  AST_FAULT: assert property (
    !fault_n |-> !gate_on && !power_good)
    else $error("gate or power good on with fault");
  AST_FLOOR: assert property (
    limit_ref >= HSST_REF_FLOOR)
    else $error("limit below floor");
  AST_TRIP: assert property (
    $past(rst_n, 2) && $stable(limit_ref) |->
    breaker_trip_level == limit_ref - HSST_CB_OFFSET)
    else $error("trip offset wrong");
  AST_UNMAPPED: assert property (
    reg_addr != HSST_FRAC_ADDR |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  CVR_TRIP: cover property ($rose(timer_up60));
  CVR_LATCH: cover property (seq_state == HSST_ST_LATCHED);
  CVR_RETRY: cover property (seq_state == HSST_ST_RETRY);
endmodule // hsst_top_asserts
`default_nettype wire

// *** verif/hsst_fet_model.sv ***
// Timer capacitor and output-voltage model facing hsst_top.
// Assumes one level unit per mV and source rates scaled per clock.
`timescale 1ns/100ps
`default_nettype none
module hsst_fet_model (
  input wire logic sys_clk,
  input wire logic timer_up3,
  input wire logic timer_up60,
  input wire logic timer_dn2,
  input wire logic timer_dn100,
  input wire logic timer_clamp_low,
  input wire logic gate_on,
  output logic timer_low_cmp,
  output logic timer_high_cmp,
  output logic power_good_cmp
);
  int v_r;
  int v_nxt;
  int pg_cnt_r;
  // The pin cannot go below ground, so the charge saturates at zero.
  assign v_nxt = v_r + (timer_up3 ? 5 : 0) + (timer_up60 ? 20 : 0)
    - (timer_dn2 ? 1 : 0) - (timer_dn100 ? 33 : 0);
  always_ff @(posedge sys_clk)
  begin
    v_r <= (timer_clamp_low || v_nxt < 0) ? 0 : v_nxt;
  end
  // Output rises slowly after the gate opens, as a loaded rail would.
  always_ff @(posedge sys_clk)
  begin
    pg_cnt_r <= gate_on ? pg_cnt_r + 1 : 0;
  end
  assign timer_low_cmp = v_r < 200;
  assign timer_high_cmp = v_r >= 1000;
  assign power_good_cmp = pg_cnt_r >= 20;
endmodule // hsst_fet_model
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for hsst_top with the timer and output model.
// Assumes a shortened start delay and retry period.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import hsst_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, operation_on = 1'b1;
  logic undervoltage_input = 1'b1, overvoltage_input = 1'b1;
  logic retry_select = 1'b1;
  logic [7:0] reg_addr = 8'hf6, reg_wdata = 8'h00, sense_level = 8'h00;
  logic [7:0] main_limit_pin = 8'h80, foldback_power_pin = 8'hff;
  logic [7:0] startup_limit_pin = 8'hff, rnd = 8'h40, e;
  logic [3:0] frac;
  wire logic [7:0] reg_rdata, limit_ref, breaker_trip_level;
  wire logic gate_on, gate_regulate, timer_up3, timer_up60, timer_dn2;
  wire logic timer_dn100, timer_clamp_low, fault_n, power_good;
  wire logic timer_low_cmp, timer_high_cmp, power_good_cmp;
  wire logic [3:0] seq_state;
  wire logic [4:0] mon;
  int bad_count, samples_checked, w;
  assign mon = {timer_dn2, timer_up60, power_good, fault_n, gate_on};
  hsst_top #(
    .INIT_MIN_CYC(400),
    .RETRY_CYC(50)
  ) dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .operation_on(operation_on),
    .main_limit_pin(main_limit_pin),
    .foldback_power_pin(foldback_power_pin),
    .startup_limit_pin(startup_limit_pin),
    .sense_level(sense_level),
    .timer_low_cmp(timer_low_cmp),
    .timer_high_cmp(timer_high_cmp),
    .undervoltage_input(undervoltage_input),
    .overvoltage_input(overvoltage_input),
    .power_good_cmp(power_good_cmp),
    .retry_select(retry_select),
    .gate_on(gate_on),
    .gate_regulate(gate_regulate),
    .limit_ref(limit_ref),
    .breaker_trip_level(breaker_trip_level),
    .timer_up3(timer_up3),
    .timer_up60(timer_up60),
    .timer_dn2(timer_dn2),
    .timer_dn100(timer_dn100),
    .timer_clamp_low(timer_clamp_low),
    .fault_n(fault_n),
    .power_good(power_good),
    .seq_state(seq_state)
  );
  hsst_fet_model u_fet (
    .sys_clk(sys_clk),
    .timer_up3(timer_up3),
    .timer_up60(timer_up60),
    .timer_dn2(timer_dn2),
    .timer_dn100(timer_dn100),
    .timer_clamp_low(timer_clamp_low),
    .gate_on(gate_on),
    .timer_low_cmp(timer_low_cmp),
    .timer_high_cmp(timer_high_cmp),
    .power_good_cmp(power_good_cmp)
  );
  // Free-running system clock.
  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic summarize();
    if (bad_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait on one watched output; running out ends the run.
  task automatic await(input int i, input logic v, input int lim,
    output int n);
    n = 0;
    while (mon[i] !== v && n < lim)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n == lim)
    begin
      bad_count++;
      $display("[FAIL] %0t wait on output %0d timed out", $time, i);
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge sys_clk);
    reg_addr <= a;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(reg_rdata, x);
  endtask
  // Re-enable by a low pulse on the supply window or the on bit.
  task automatic toggle(input int m);
    @(posedge sys_clk);
    if (m == 0)
      undervoltage_input <= 1'b0;
    else
      operation_on <= 1'b0;
    @(posedge sys_clk);
    undervoltage_input <= 1'b1;
    operation_on <= 1'b1;
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] lim(input logic [7:0] m, f, s,
    input logic [3:0] n, input logic pg);
    logic [11:0] r;
    logic [7:0] l;
    r = ({4'h0, m} * ({8'h0, n} + 12'h001)) >> 4;
    l = (m < f) ? m : f;
    if (!pg && s < l) l = s;
    if (!pg && r[7:0] < l) l = r[7:0];
    return (l < HSST_REF_FLOOR) ? HSST_REF_FLOOR : l;
  endfunction
  // Main sequence; supply stays out of window until limits are checked.
  initial
  begin
    repeat (12) @(negedge sys_clk);
    chk({6'h0, gate_on, timer_clamp_low}, 8'h01);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(HSST_FRAC_ADDR, {4'h0, HSST_FRAC_RESET});
    for (int k = 0; k < 12; k++)
    begin
      rnd = lfsr(rnd);
      frac = (k == 1) ? 4'h0 : rnd[3:0];
      wr(HSST_FRAC_ADDR, {4'h0, frac});
      main_limit_pin <= (k == 0) ? 8'h00 : lfsr(rnd);
      foldback_power_pin <= rnd ^ 8'h5a;
      startup_limit_pin <= (k == 2) ? 8'h03 : ~rnd;
      rd(HSST_FRAC_ADDR, {4'h0, frac});
      e = lim(main_limit_pin, foldback_power_pin, startup_limit_pin, frac,
        1'b0);
      chk(limit_ref, e);
      chk(breaker_trip_level, e - HSST_CB_OFFSET);
    end
    wr(8'hf7, 8'h05);
    rd(8'hf7, 8'h00);
    rd(HSST_FRAC_ADDR, {4'h0, frac});
    wr(HSST_FRAC_ADDR, 8'h0f);
    main_limit_pin <= 8'h80;
    foldback_power_pin <= 8'hff;
    startup_limit_pin <= 8'h10;
    repeat (600) @(negedge sys_clk);
    chk({7'h0, gate_on}, 8'h00);
    @(posedge sys_clk);
    overvoltage_input <= 1'b0;
    await(0, 1'b1, 100, w);
    chk(limit_ref, 8'h10);
    await(2, 1'b1, 200, w);
    repeat (4) @(negedge sys_clk);
    chk(limit_ref, 8'h80);
    @(posedge sys_clk);
    sense_level <= 8'hff;
    await(3, 1'b1, 20, w);
    chk({7'h0, gate_regulate}, 8'h01);
    @(posedge sys_clk);
    sense_level <= 8'h00;
    await(4, 1'b1, 20, w);
    for (int m = 0; m < 3; m++)
    begin
      await(0, 1'b1, 3000, w);
      @(posedge sys_clk);
      retry_select <= (m != 2);
      sense_level <= 8'hff;
      await(1, 1'b0, 300, w);
      chk({6'h0, gate_on, power_good}, 8'h00);
      @(posedge sys_clk);
      sense_level <= 8'h00;
      if (m < 2)
      begin
        toggle(m);
        repeat (20) @(negedge sys_clk);
        chk({7'h0, gate_on}, 8'h00);
        await(4, 1'b0, 2000, w);
        repeat (100) @(negedge sys_clk);
        chk({7'h0, gate_on}, 8'h00);
        toggle(m);
      end
      await(0, 1'b1, 3000, w);
    end
    summarize();
  end
endmodule // testbench
bind hsst_top hsst_top_asserts #(
  .INIT_MIN_CYC(INIT_MIN_CYC)
) u_asserts (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .reg_addr(reg_addr),
  .reg_rdata(reg_rdata),
  .limit_ref(limit_ref),
  .breaker_trip_level(breaker_trip_level),
  .gate_on(gate_on),
  .gate_regulate(gate_regulate),
  .timer_up3(timer_up3),
  .timer_up60(timer_up60),
  .timer_dn2(timer_dn2),
  .timer_dn100(timer_dn100),
  .timer_clamp_low(timer_clamp_low),
  .fault_n(fault_n),
  .power_good(power_good),
  .seq_state(seq_state)
);
`default_nettype wire
